// ---- common/touch_adc_pkg.sv ----
// Shared constants and carrier types for the touch converter serial sequencer.
// Assumes the sequencer and its result shifter are compiled after this package.
package touch_adc_pkg;

    // ------------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------------
    localparam int CTRL_W = 8;
    localparam int CTRL_MSB = 7;
    localparam logic [2:0] CNT_W_ZERO = 3'h0;
    localparam logic [2:0] CNT_FIRST = 3'h1;
    localparam logic [2:0] CNT_ACQ_START = 3'h4;
    localparam logic [2:0] CNT_REF_BIT = 3'h5;
    localparam logic [2:0] CNT_LAST = 3'h7;

    // ------------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------------
    localparam logic [2:0] CHAN_Y_DRIVE = 3'h1;
    localparam logic [2:0] CHAN_X_DRIVE = 3'h5;
    localparam logic [1:0] PD_ALWAYS_ON = 2'h3;
    localparam logic [1:0] PD_RESET = 2'h0;
    localparam int RES_BITS_12 = 12;
    localparam int RES_BITS_8 = 8;
    localparam int ACQ_CLOCKS = 3;
    localparam int FRAME_CLOCKS = 24;

    typedef struct packed {
        logic start;
        logic [2:0] channelSelectField;
        logic mode8;
        logic refSelectSingleEnded;
        logic [1:0] powerMgmtField;
    } ctrl_word_t;

    localparam ctrl_word_t CTRL_RESET = '0;

    typedef enum logic [1:0] {
        RX_HUNT = 2'h0,
        RX_ADDR = 2'h1,
        RX_ACQ = 2'h3
    } rx_state_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'h0,
        CV_ARMED = 2'h1,
        CV_BUSY = 2'h3,
        CV_SHIFT = 2'h2
    } cv_state_t;

    typedef struct packed {
        logic csN;
        logic convSerialClock;
        logic din;
    } serial_in_t;

    typedef struct packed {
        logic dout;
        logic doutOe;
        logic busy;
        logic busyOe;
    } serial_out_t;

    typedef struct packed {
        logic xDriveOn;
        logic yDriveOn;
        logic yMinusOn;
        logic refPowerOn;
        logic adcPowerOn;
        logic trackHold;
    } panel_ctrl_t;

endpackage

// ---- logic/sar_result_shifter.sv ----
// Result shift register that presents one conversion bit per falling clock edge.
// Assumes load, shift and clear come from logic on sys_clk.
`timescale 1ns/100ps
module sar_result_shifter #(
    parameter int WIDTH = 12
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic load,
    input wire logic mode8,
    input wire logic [WIDTH-1:0] code,
    input wire logic shift,
    output logic bitOut,
    output logic lastBit
);
    import touch_adc_pkg::*;

    localparam int CNT_W = $clog2(WIDTH + 1);

    if (WIDTH < RES_BITS_8 || WIDTH > 16) begin : g_check
        $error("sar_result_shifter WIDTH must be 8 to 16");
    end

    typedef struct packed {
        logic [WIDTH-1:0] sr;
        logic [CNT_W-1:0] cnt;
        logic bitOut;
    } sh_state_t;

    sh_state_t q;
    sh_state_t n;

    always_comb begin
        n = q;
        if (clear) begin
            n = '0;
        end else if (load) begin
            if (mode8) begin
                n.sr = {code[WIDTH-1 -: RES_BITS_8], {(WIDTH - RES_BITS_8){1'b0}}};
                n.cnt = CNT_W'(RES_BITS_8);
            end else begin
                n.sr = code;
                n.cnt = CNT_W'(WIDTH);
            end
        end else if (shift) begin
            // Once the count runs out only zeros follow.
            n.bitOut = (q.cnt != '0) ? q.sr[WIDTH-1] : 1'b0;
            n.sr = {q.sr[WIDTH-2:0], 1'b0};
            n.cnt = (q.cnt != '0) ? q.cnt - CNT_W'(1) : '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign bitOut = q.bitOut;
    assign lastBit = (q.cnt == CNT_W'(1));
endmodule

// ---- logic/touch_adc_serial_sequencer.sv ----
// Serial control and conversion sequencer of the touch converter.
// Assumes the host drives chip select, serial clock and data; sampleCode and
// penDetect come from the analog side on sys_clk.
`timescale 1ns/100ps
module touch_adc_serial_sequencer #(
    parameter int RESULT_W = 12
) (
    input wire logic sys_clk,
    input wire logic srst,
    input touch_adc_pkg::serial_in_t pins,
    input wire logic [RESULT_W-1:0] sampleCode,
    input wire logic penDetect,
    output touch_adc_pkg::serial_out_t pinsOut,
    output touch_adc_pkg::panel_ctrl_t panel,
    output touch_adc_pkg::ctrl_word_t ctrlWord,
    output logic penTouchInterruptN
);
    import touch_adc_pkg::*;

    if (RESULT_W != RES_BITS_12) begin : g_check
        $error("touch_adc_serial_sequencer supports a 12-bit result only");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] csS;
        logic [1:0] sclkS;
        logic [1:0] dinS;
        logic [1:0] penS;
        logic sclkPrev;
        logic frame;
        rx_state_t rx;
        logic [2:0] rxCnt;
        ctrl_word_t ctrl;
        logic [1:0] pdAct;
        logic acqSer;
        cv_state_t cv;
        logic busy;
        logic hold;
        logic drvX;
        logic drvY;
        logic yMinus;
        logic adcOn;
        logic penIrqN;
    } seq_state_t;

    localparam seq_state_t SEQ_RESET = '{
        csS: 2'h3,
        sclkS: 2'h0,
        dinS: 2'h0,
        penS: 2'h0,
        sclkPrev: 1'b0,
        frame: 1'b0,
        rx: RX_HUNT,
        rxCnt: CNT_W_ZERO,
        ctrl: CTRL_RESET,
        pdAct: PD_RESET,
        acqSer: 1'b0,
        cv: CV_IDLE,
        busy: 1'b0,
        hold: 1'b0,
        drvX: 1'b0,
        drvY: 1'b0,
        yMinus: 1'b0,
        adcOn: 1'b0,
        penIrqN: 1'b1
    };

    seq_state_t q;
    seq_state_t n;

    logic rise;
    logic fall;
    logic csLow;
    logic shLoad;
    logic shShift;
    logic shClear;
    logic shBit;
    logic shLast;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [CTRL_W-1:0] bits;
        logic [2:0] pos;
        bits = q.ctrl;
        pos = CNT_W_ZERO;
        n = q;
        shLoad = 1'b0;
        shShift = 1'b0;
        shClear = 1'b0;

        // Pins cross into sys_clk through two flops; edges use the second only.
        n.csS = {q.csS[0], pins.csN};
        n.sclkS = {q.sclkS[0], pins.convSerialClock};
        n.dinS = {q.dinS[0], pins.din};
        n.penS = {q.penS[0], penDetect};
        n.sclkPrev = q.sclkS[1];
        rise = q.sclkS[1] & ~q.sclkPrev;
        fall = ~q.sclkS[1] & q.sclkPrev;
        csLow = ~q.csS[1];
        n.frame = csLow;

        if (!csLow) begin
            // Leaving the frame aborts any conversion and opens the drivers.
            n.rx = RX_HUNT;
            n.rxCnt = CNT_W_ZERO;
            n.cv = CV_IDLE;
            n.busy = 1'b0;
            n.hold = 1'b0;
            n.drvX = 1'b0;
            n.drvY = 1'b0;
            shClear = 1'b1;
        end else if (rise) begin
            // Edges are counted, not timed, so bursts with pauses work.
            pos = 3'(CTRL_MSB) - q.rxCnt;
            case (q.rx)
                RX_HUNT: begin
                    if (q.dinS[1]) begin
                        bits[CTRL_MSB] = 1'b1;
                        n.ctrl = ctrl_word_t'(bits);
                        n.rxCnt = CNT_FIRST;
                        n.rx = RX_ADDR;
                    end
                end
                RX_ADDR: begin
                    bits[pos] = q.dinS[1];
                    n.ctrl = ctrl_word_t'(bits);
                    n.rxCnt = q.rxCnt + CNT_FIRST;
                    if (q.rxCnt == CNT_ACQ_START) begin
                        // Channel bits are settled: start acquiring.
                        n.rx = RX_ACQ;
                        // Fresh decode drops drivers held from an older word.
                        n.drvY = (q.ctrl.channelSelectField == CHAN_Y_DRIVE);
                        n.drvX = (q.ctrl.channelSelectField == CHAN_X_DRIVE);
                        n.yMinus = 1'b0;
                    end
                end
                RX_ACQ: begin
                    bits[pos] = q.dinS[1];
                    n.ctrl = ctrl_word_t'(bits);
                    n.rxCnt = q.rxCnt + CNT_FIRST;
                    if (q.rxCnt == CNT_REF_BIT) begin
                        n.acqSer = q.dinS[1];
                    end
                    if (q.rxCnt == CNT_LAST) begin
                        // Power bits only apply once the word is whole.
                        n.pdAct = {q.ctrl.powerMgmtField[1], q.dinS[1]};
                        n.rx = RX_HUNT;
                        n.rxCnt = CNT_W_ZERO;
                        // An overlapped word restarts the converter.
                        n.cv = CV_ARMED;
                    end
                end
                default: begin
                    n.rx = RX_HUNT;
                    n.rxCnt = CNT_W_ZERO;
                end
            endcase
        end else if (fall) begin
            shShift = 1'b1;
            case (q.cv)
                CV_IDLE: begin
                end
                CV_ARMED: begin
                    // Sample is held and busy rises on this edge.
                    shLoad = 1'b1;
                    n.busy = 1'b1;
                    n.hold = 1'b1;
                    n.cv = CV_BUSY;
                    if (q.acqSer) begin
                        n.drvX = 1'b0;
                        n.drvY = 1'b0;
                    end
                end
                CV_BUSY, CV_SHIFT: begin
                    // Drivers left on here for a differential reference.
                    n.busy = 1'b0;
                    n.cv = CV_SHIFT;
                    if (shLast) begin
                        // Count ends after 12 or 8 bits.
                        n.cv = CV_IDLE;
                        n.hold = 1'b0;
                        if (q.pdAct != PD_ALWAYS_ON) begin
                            n.yMinus = 1'b1;
                            n.drvX = 1'b0;
                            n.drvY = 1'b0;
                        end
                    end
                end
                default: begin
                    n.cv = CV_IDLE;
                end
            endcase
        end

        // A pending conversion keeps the converter up across host pauses.
        n.adcOn = q.pdAct[0] | (q.cv != CV_IDLE) | (q.rx == RX_ACQ) | (n.cv != CV_IDLE);
        n.penIrqN = ~(q.penS[1] & (q.pdAct != PD_ALWAYS_ON));
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= SEQ_RESET;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Result shifter
    // ------------------------------------------------------------------
    sar_result_shifter #(
        .WIDTH(RESULT_W)
    ) u_shifter (
        .sys_clk(sys_clk),
        .srst(srst),
        .clear(shClear),
        .load(shLoad),
        .mode8(q.ctrl.mode8),
        .code(sampleCode),
        .shift(shShift),
        .bitOut(shBit),
        .lastBit(shLast)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Enables follow the synchronised select, so they lag the pin by three cycles.
    assign pinsOut.dout = shBit;
    assign pinsOut.doutOe = q.frame;
    assign pinsOut.busy = q.busy;
    assign pinsOut.busyOe = q.frame;
    assign panel.xDriveOn = q.drvX;
    assign panel.yDriveOn = q.drvY;
    assign panel.yMinusOn = q.yMinus;
    assign panel.refPowerOn = q.pdAct[1];
    assign panel.adcPowerOn = q.adcOn;
    assign panel.trackHold = q.hold;
    assign ctrlWord = q.ctrl;
    assign penTouchInterruptN = q.penIrqN;
endmodule

// ---- verif/touch_adc_serial_sequencer_sva.sv ----
// Port checker of the touch converter sequencer, bound to its top module.
// Assumes serial clock half periods of four sys_clk cycles from the bench.
`timescale 1ns/100ps
module touch_adc_serial_sequencer_sva #(
    parameter int RESULT_W = 12
) (
    input wire logic sys_clk,
    input wire logic srst,
    input touch_adc_pkg::serial_in_t pins,
    input wire logic [RESULT_W-1:0] sampleCode,
    input wire logic penDetect,
    input touch_adc_pkg::serial_out_t pinsOut,
    input touch_adc_pkg::panel_ctrl_t panel,
    input touch_adc_pkg::ctrl_word_t ctrlWord,
    input wire logic penTouchInterruptN
);
    import touch_adc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Falls are counted, not cycles, so host pauses do not disturb the figure.
    logic [3:0] holdFalls_q;
    always_ff @(posedge sys_clk) begin
        if (srst || !panel.trackHold) begin
            holdFalls_q <= 4'h0;
        end else if ($past(pins.convSerialClock) && !pins.convSerialClock) begin
            holdFalls_q <= holdFalls_q + 4'h1;
        end
    end
    sequence serialFell;
        !$past(pins.convSerialClock, 3) && $past(pins.convSerialClock, 6);
    endsequence
    sequence csHeldLow;
        $fell(pins.csN) ##1 !pins.csN [*5];
    endsequence
    AST_OE_ON: assert property (csHeldLow |-> pinsOut.doutOe && pinsOut.busyOe)
        else $error("outputs float with chip select low");
    AST_OE_OFF: assert property (pins.csN [*6] |-> !pinsOut.doutOe && !pinsOut.busyOe)
        else $error("outputs driven with chip select high");
    AST_BUSY_EDGE: assert property ($rose(pinsOut.busy) |-> serialFell ##0 panel.trackHold)
        else $error("busy rose without a serial fall and hold");
    AST_BUSY_LEN: assert property ($rose(pinsOut.busy) |-> pinsOut.busy [*8] ##1 !pinsOut.busy)
        else $error("busy not one serial period long");
    AST_HOLD_LEN: assert property ($fell(panel.trackHold) && !pins.csN |->
        (holdFalls_q == 4'hC || holdFalls_q == 4'h8))
        else $error("conversion length wrong");
    AST_YMINUS: assert property ($rose(panel.yMinusOn) |-> $fell(panel.trackHold))
        else $error("Y-minus switched on outside conversion end");
    AST_DRV_EXCL: assert property (!(panel.xDriveOn && panel.yDriveOn))
        else $error("both drivers on");
    AST_DRV_DECODE: assert property (($rose(panel.xDriveOn) |->
        ctrlWord.channelSelectField == CHAN_X_DRIVE) and ($rose(panel.yDriveOn) |->
        ctrlWord.channelSelectField == CHAN_Y_DRIVE))
        else $error("driver on for wrong channel");
    AST_CS_DRV: assert property (pins.csN [*6] |-> !panel.xDriveOn && !panel.yDriveOn)
        else $error("drivers on with chip select high");
    AST_PEN: assert property ($fell(penTouchInterruptN) |->
        $past(penDetect, 3) && ctrlWord.powerMgmtField != PD_ALWAYS_ON)
        else $error("pen interrupt asserted without cause");
endmodule
bind touch_adc_serial_sequencer touch_adc_serial_sequencer_sva #(.RESULT_W(RESULT_W)) chk (
    .sys_clk(sys_clk), .srst(srst), .pins(pins), .sampleCode(sampleCode),
    .penDetect(penDetect), .pinsOut(pinsOut), .panel(panel), .ctrlWord(ctrlWord),
    .penTouchInterruptN(penTouchInterruptN));

// ---- verif/touch_adc_serial_sequencer_tb.sv ----
// Self-checking bench of the touch converter sequencer.
// Assumes the host model drives all serial pins of the block.
`timescale 1ns/100ps
module touch_adc_serial_sequencer_tb;
    import touch_adc_pkg::*;
    logic sys_clk;
    logic srst;
    logic [11:0] sampleCode;
    logic penDetect;
    serial_in_t pins;
    serial_out_t pinsOut;
    panel_ctrl_t panel;
    ctrl_word_t ctrlWord;
    logic penTouchInterruptN;
    int errTotal;
    int nTests;
    logic [7:0] words [5] = '{8'hD3, 8'h97, 8'hDC, 8'h91, 8'hE2};
    logic [11:0] codes [5] = '{12'hA5C, 12'h3C1, 12'hF0F, 12'h801, 12'h7FE};
    touch_adc_serial_sequencer #(.RESULT_W(12)) uut (.sys_clk(sys_clk), .srst(srst),
        .pins(pins), .sampleCode(sampleCode), .penDetect(penDetect), .pinsOut(pinsOut),
        .panel(panel), .ctrlWord(ctrlWord), .penTouchInterruptN(penTouchInterruptN));
    touch_host_model host (.sys_clk(sys_clk), .pins(pins), .pinsOut(pinsOut));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic check(input logic ok, input string msg);
        nTests++;
        if (ok !== 1'b1) begin
            errTotal++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic t_frame(input logic [7:0] w, input logic [11:0] code, input logic burst,
            input int lead, input logic pen);
        logic [14:0] expTail;
        logic [2:0] ch;
        logic pdOn;
        expTail = w[3] ? {code[11:4], 7'h00} : {code, 3'h0};
        ch = w[6:4];
        pdOn = (w[1:0] == PD_ALWAYS_ON);
        sampleCode = code;
        penDetect = pen;
        host.rxBits = '0;
        host.select(1'b0);
        check(pinsOut.doutOe === 1'b1 && pinsOut.busyOe === 1'b1, "outputs off");
        host.shift({w, 24'h0} >> lead, lead + 4);
        check(ctrlWord.channelSelectField === ch, "partial word");
        host.shift({w[3:0], 28'h0}, 4);
        check(ctrlWord === w, "control word");
        check(panel.xDriveOn === (ch == CHAN_X_DRIVE) && panel.yDriveOn === (ch == CHAN_Y_DRIVE),
            "acquisition drivers");
        if (burst) begin
            host.waitClk(20);
            check(panel.adcPowerOn === 1'b1, "power in pause");
        end
        host.shift(32'h0, 8);
        if (burst) begin
            host.waitClk(20);
            check(panel.trackHold === 1'b1 && panel.adcPowerOn === 1'b1, "hold");
            check(panel.xDriveOn === (ch == CHAN_X_DRIVE && !w[2]), "drive in hold");
        end
        host.shift(32'h0, 8);
        check(host.rxBits[14:0] === expTail, "result");
        check(panel.yMinusOn === !pdOn, "Y-minus");
        check(panel.refPowerOn === w[1], "reference power");
        check(panel.xDriveOn === (pdOn && !w[2] && ch == CHAN_X_DRIVE), "drive kept");
        check(penTouchInterruptN === !(pen && !pdOn), "pen interrupt");
        host.select(1'b1);
        check(pinsOut.doutOe === 1'b0 && panel.xDriveOn === 1'b0, "deselect");
    endtask
    task automatic t_overlap(input logic [7:0] wa, input logic [7:0] wb, input int gap,
            input logic [11:0] ca, input logic [11:0] cb);
        logic [11:0] mask;
        mask = wa[3] ? 12'hFF0 : 12'hFFF;
        sampleCode = ca;
        host.rxBits = '0;
        host.select(1'b0);
        fork
            host.shift({wa, 24'h0}, gap);
            begin
                host.waitClk(80);
                sampleCode = cb;
            end
        join
        host.shift({wb, 24'h0}, 24);
        check((host.rxBits[gap+14 -: 12] & mask) === (ca & mask), "first");
        check((host.rxBits[14:3] & mask) === (cb & mask), "second");
        check(ctrlWord === wb, "second word");
        host.select(1'b1);
    endtask
    // A frame cut in mid-conversion must drop hold and drivers without closing the panel.
    task automatic t_abort(input logic [7:0] w, input logic [11:0] code);
        sampleCode = code;
        host.select(1'b0);
        host.shift({w, 24'h0}, 12);
        check(panel.trackHold === 1'b1 && panel.yDriveOn === (w[6:4] == CHAN_Y_DRIVE),
            "mid conversion");
        host.select(1'b1);
        check(panel.trackHold === 1'b0 && panel.yMinusOn === 1'b0 && panel.yDriveOn === 1'b0,
            "abort");
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        errTotal++;
        $display("unexpected at %0t: run hung", $time);
        results();
    end
    initial begin
        errTotal = 0;
        nTests = 0;
        srst = 1'b1;
        sampleCode = 12'h000;
        penDetect = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 srst = 1'b0;
        host.waitClk(4);
        check(ctrlWord === CTRL_RESET && panel === 6'h00 && pinsOut === 4'h0, "reset");
        check(penTouchInterruptN === 1'b1, "pen idle");
        for (int i = 0; i < 5; i++) begin
            t_frame(words[i], codes[i], !i[0], (i == 1) ? 3 : 0, i != 3);
        end
        t_overlap(8'hD3, 8'h97, 16, codes[0], codes[1]);
        t_overlap(8'hD3, 8'hD3, 15, codes[2], codes[3]);
        t_overlap(8'hDB, 8'h9F, 11, codes[4], codes[0]);
        t_abort(words[3], codes[1]);
        results();
    end
endmodule

// ---- verif/touch_host_model.sv ----
// Host serial master model: chip select, serial clock and serial data in.
// Assumes a 10 MHz sys_clk; one serial half period is four sys_clk cycles.
`timescale 1ns/100ps
module touch_host_model (
    input wire logic sys_clk,
    output touch_adc_pkg::serial_in_t pins,
    input touch_adc_pkg::serial_out_t pinsOut
);
    import touch_adc_pkg::*;
    logic [63:0] rxBits;
    initial begin
        pins = 3'h4;
        rxBits = '0;
    end
    task automatic waitClk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // The serial clock idles low and runs only inside a frame.
    task automatic select(input logic csN);
        pins.convSerialClock = 1'b0;
        waitClk(4);
        pins.csN = csN;
        waitClk(8);
    endtask
    // Pauses fall with the clock high, so bursts of any length are legal.
    task automatic shift(input logic [31:0] tx, input int n);
        for (int i = 0; i < n; i++) begin
            pins.convSerialClock = 1'b0;
            pins.din = tx[31 - i];
            waitClk(4);
            pins.convSerialClock = 1'b1;
            waitClk(4);
            rxBits = {rxBits[62:0], pinsOut.dout};
        end
    endtask
endmodule
